// ### tb/quad_port_burst4_sram_core_test.sv
`timescale 1ns/10ps
`include "sram_link_regs.svh"
module quad_port_burst4_sram_core_test;
   logic clk = 1'h0;
   logic rst = 1'h1;
   logic dev_rst = 1'h1;
   logic dll_enable = 1'h1;
   logic rd_req = 1'h0;
   logic wr_req = 1'h0;
   link_pkg::addr_type rd_addr = link_pkg::addr_type'(4'h0);
   link_pkg::addr_type wr_addr = link_pkg::addr_type'(4'h0);
   link_pkg::burst_type wr_data = link_pkg::burst_type'(4'h0);
   link_pkg::burst_mask_type wr_mask_n = link_pkg::burst_mask_type'(16'hFFFF);
   logic rd_ready;
   logic wr_ready;
   logic rd_valid;
   link_pkg::burst_type rd_data;
   int n_fail = 0;
   int n_compared = 0;
   initial begin
      forever #20 clk = ~clk;
   end
   sram_link_if sram_link_if_inst ();
   sram_ctl_end sram_ctl_end_inst (.clk(clk), .rst(rst), .dll_enable(dll_enable),
      .rd_req(rd_req), .rd_addr(rd_addr), .rd_ready(rd_ready), .wr_req(wr_req),
      .wr_addr(wr_addr), .wr_data(wr_data), .wr_mask_n(wr_mask_n), .wr_ready(wr_ready),
      .rd_valid(rd_valid), .rd_data(rd_data), .link(sram_link_if_inst.ctl));
   sram_device_end sram_device_end_inst (.link(sram_link_if_inst.dev), .rst(dev_rst));
   sram_link_chk sram_link_chk_inst (.k(sram_link_if_inst.k), .rst(dev_rst),
      .rd_sel_n(sram_link_if_inst.rd_sel_n), .wr_sel_n(sram_link_if_inst.wr_sel_n),
      .lane_write_n(sram_link_if_inst.lane_write_n), .loop_on(sram_link_if_inst.loop_on),
      .out_valid_flag(sram_link_if_inst.out_valid_flag),
      .echo_strobe(sram_link_if_inst.echo_strobe),
      .echo_strobe_inverted(sram_link_if_inst.echo_strobe_inverted));

   function automatic link_pkg::burst_type pat(input int s);
      link_pkg::burst_type r;
      for (int b = 0; b < 4; b++) r[b] = link_pkg::word_type'(36'h9A5C30F00 + s * 64 + b);
      return r;
   endfunction
   function automatic link_pkg::burst_type merged(input link_pkg::burst_type o,
      input link_pkg::burst_type n, input link_pkg::burst_mask_type m);
      link_pkg::burst_type r;
      r = o;
      for (int b = 0; b < 4; b++) begin
         for (int l = 0; l < `LANES; l++) begin
            if (!m[b][l]) r[b][l*`LANE_W +: `LANE_W] = n[b][l*`LANE_W +: `LANE_W];
         end
      end
      return r;
   endfunction
   task automatic compare(input link_pkg::burst_type exp, input link_pkg::burst_type got);
      n_compared++;
      if (got !== exp) begin
         n_fail++;
         $display("unexpected at %0t: burst %h, wanted %h", $time, got, exp);
      end
   endtask
   // ready is sampled mid-cycle so the taking edge is known before it lands
   task automatic do_write(input int a, input link_pkg::burst_type d,
      input link_pkg::burst_mask_type m);
      logic ok;
      int n;
      n = 0;
      @(posedge clk);
      wr_addr <= link_pkg::addr_type'(a);
      wr_data <= d;
      wr_mask_n <= m;
      wr_req <= 1'h1;
      do begin
         @(negedge clk);
         ok = wr_ready;
         @(posedge clk);
      end while (ok !== 1'h1 && n++ < 20);
      wr_req <= 1'h0;
      if (ok !== 1'h1) begin
         n_fail++;
         $display("unexpected at %0t: write never taken", $time);
      end
   endtask
   task automatic do_read(input int a, output link_pkg::burst_type q);
      logic ok;
      int n;
      n = 0;
      @(posedge clk);
      rd_addr <= link_pkg::addr_type'(a);
      rd_req <= 1'h1;
      do begin
         @(negedge clk);
         ok = rd_ready;
         @(posedge clk);
      end while (ok !== 1'h1 && n++ < 20);
      rd_req <= 1'h0;
      n = 0;
      do @(negedge clk); while (rd_valid !== 1'h1 && n++ < 60);
      if (rd_valid !== 1'h1) begin
         n_fail++;
         $display("unexpected at %0t: no read answer", $time);
      end
      q = rd_data;
   endtask

   task automatic t_write_read();
      link_pkg::burst_type q;
      do_write(3, pat(1), link_pkg::burst_mask_type'(16'h0000));
      do_read(3, q);
      compare(pat(1), q);
      do_read(12, q);
      compare(link_pkg::burst_type'(4'h0), q);
   endtask
   // one lane per beat, last beat none; read follows at once to hit the buffer
   task automatic t_lanes();
      link_pkg::burst_type q;
      link_pkg::burst_mask_type m;
      m = link_pkg::burst_mask_type'(16'hFBDE);
      do_write(5, pat(2), link_pkg::burst_mask_type'(16'h0000));
      do_write(5, pat(3), m);
      do_read(5, q);
      compare(merged(pat(2), pat(3), m), q);
   endtask
   task automatic t_concurrent();
      link_pkg::burst_type q;
      fork
         do_write(7, pat(4), link_pkg::burst_mask_type'(16'h0000));
         do_read(3, q);
      join
      compare(pat(1), q);
      do_read(7, q);
      compare(pat(4), q);
   endtask
   task automatic t_bypass();
      link_pkg::burst_type q;
      @(posedge clk);
      dll_enable <= 1'h0;
      repeat (40) @(posedge clk);
      do_write(9, pat(5), link_pkg::burst_mask_type'(16'h0000));
      repeat (16) @(posedge clk);
      do_read(9, q);
      compare(pat(5), q);
      @(posedge clk);
      dll_enable <= 1'h1;
      repeat (40) @(posedge clk);
   endtask
   task automatic give_verdict();
      $display("compared %0d, mismatches %0d", n_compared, n_fail);
      if (n_fail == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   // device end resets on link rises, which only run once the controller is out
   initial begin
      repeat (12) @(posedge clk);
      rst <= 1'h0;
      repeat (16) @(posedge clk);
      dev_rst <= 1'h0;
      repeat (16) @(posedge clk);
      t_write_read();
      t_lanes();
      t_concurrent();
      t_bypass();
      give_verdict();
   end
   initial begin
      #(40 * 3000);
      n_fail++;
      $display("unexpected at %0t: run did not finish", $time);
      give_verdict();
   end
endmodule

// ### tb/sram_link_chk.sv
`timescale 1ns/10ps
module sram_link_chk (
   input wire logic k,
   input wire logic rst,
   input wire logic rd_sel_n,
   input wire logic wr_sel_n,
   input wire link_pkg::mask_type lane_write_n,
   input wire logic loop_on,
   input wire logic out_valid_flag,
   input wire logic echo_strobe,
   input wire logic echo_strobe_inverted
);
   sequence rd_cmd;
      !rd_sel_n;
   endsequence
   sequence two_beats;
      out_valid_flag [*2];
   endsequence
   // sampled at k rise the bus shows the low-half register
   a_echo_low_half: assert property (@(posedge k) disable iff (rst)
      !echo_strobe && echo_strobe_inverted) else $error("echo pair wrong in low half");
   a_echo_high_half: assert property (@(negedge k) disable iff (rst)
      echo_strobe && !echo_strobe_inverted) else $error("echo pair wrong in high half");
   a_read_latency_on: assert property (@(posedge k) disable iff (rst)
      (loop_on && $past(loop_on, 4)) ##0 rd_cmd |-> ##3 two_beats)
      else $error("read beats late or early with loop on");
   a_read_latency_off: assert property (@(posedge k) disable iff (rst)
      (!loop_on && !$past(loop_on, 4)) ##0 rd_cmd |-> ##2 two_beats)
      else $error("read beats wrong in bypass");
   a_valid_high_half: assert property (@(negedge k) disable iff (rst)
      (loop_on && $past(loop_on, 4)) ##0 rd_cmd |-> ##2 out_valid_flag ##1 out_valid_flag)
      else $error("valid missing in high half");
   a_valid_has_cause: assert property (@(posedge k) disable iff (rst)
      out_valid_flag |-> !$past(rd_sel_n, 2) || !$past(rd_sel_n, 3) || !$past(rd_sel_n, 4))
      else $error("valid without a read");
   a_read_slot_alone: assert property (@(posedge k) disable iff (rst)
      rd_cmd |-> wr_sel_n ##1 rd_sel_n) else $error("read slot shared or repeated");
   a_write_spacing: assert property (@(posedge k) disable iff (rst)
      !wr_sel_n |=> wr_sel_n) else $error("writes on adjacent rises");
   a_mask_rise_beats: assert property (@(posedge k) disable iff (rst)
      !(&lane_write_n) |-> !$past(wr_sel_n, 1) || !$past(wr_sel_n, 2))
      else $error("lane mask at rise outside a write");
   a_mask_fall_beats: assert property (@(negedge k) disable iff (rst)
      !(&lane_write_n) |-> !$past(wr_sel_n, 1) || !$past(wr_sel_n, 2))
      else $error("lane mask at fall outside a write");
endmodule

// ### verilog/link_pkg.sv
`include "sram_link_regs.svh"
package link_pkg;
   typedef logic [`DATA_W-1:0] word_type;
   typedef logic [`LANES-1:0] mask_type;
   typedef logic [`ADDR_W-1:0] addr_type;
   typedef logic [`STORE_BITS-1:0] line_type;
   typedef word_type [`BURST_LEN-1:0] burst_type;
   typedef mask_type [`BURST_LEN-1:0] burst_mask_type;
   typedef word_type [1:0] pair_type;
   typedef mask_type [1:0] pair_mask_type;
   typedef burst_type [`STORE_LINES-1:0] store_type;

   typedef struct packed {
      logic meta;
      logic stable;
   } sync_type;

   typedef struct packed {
      logic rd_v1;
      line_type rd_a1;
      logic rd_v2;
      line_type rd_a2;
      logic wr_v1;
      line_type wr_a1;
      logic wr_v2;
      line_type wr_a2;
      logic wr_v3;
      line_type wr_a3;
      word_type beat_d;
      mask_type beat_m;
      logic fetch_v;
      pair_type fetch_d;
      logic launch_v;
      pair_type launch_d;
      store_type mem;
   } dev_rise_type;

   typedef struct packed {
      word_type d;
      mask_type m;
      word_type q;
      logic valid;
   } dev_fall_type;

   typedef struct packed {
      logic [1:0] phase;
      logic slot;
      logic k;
      logic rd_sel;
      logic wr_sel;
      addr_type addr;
      word_type d;
      mask_type lane_on;
      burst_type stage_d;
      burst_mask_type stage_m;
      logic [1:0] stage_delay;
      burst_type shift_d;
      burst_mask_type shift_m;
      logic [3:0] shift_v;
      word_type q1;
      word_type q2;
      logic v1;
      logic v2;
      burst_type col;
      logic [1:0] col_cnt;
      logic rd_valid;
      burst_type rd_data;
   } ctl_type;

   function automatic word_type merge_lanes(word_type old_w, word_type new_w, mask_type lane_n);
      word_type res;
      res = old_w;
      for (int l = 0; l < `LANES; l++) begin
         if (!lane_n[l]) begin
            res[l*`LANE_W +: `LANE_W] = new_w[l*`LANE_W +: `LANE_W];
         end
      end
      return res;
   endfunction
endpackage

// ### verilog/sram_ctl_end.sv
`timescale 1ns/10ps
`include "sram_link_regs.svh"
module sram_ctl_end (
   input wire logic clk,
   input wire logic rst,
   input wire logic dll_enable,
   input wire logic rd_req,
   input wire link_pkg::addr_type rd_addr,
   output logic rd_ready,
   input wire logic wr_req,
   input wire link_pkg::addr_type wr_addr,
   input wire link_pkg::burst_type wr_data,
   input wire link_pkg::burst_mask_type wr_mask_n,
   output logic wr_ready,
   output logic rd_valid,
   output link_pkg::burst_type rd_data,
   sram_link_if.ctl link
);
   link_pkg::ctl_type s_r;
   link_pkg::ctl_type s_nxt;
   logic rise_prep;
   logic fall_prep;

   // one command slot per link cycle, reads and writes taking turns
   assign rd_ready = (s_r.phase == 2'h0) && !s_r.slot;
   assign wr_ready = (s_r.phase == 2'h0) && s_r.slot;

   always_comb begin
      s_nxt = s_r;
      s_nxt.phase = s_r.phase + 2'h1;
      s_nxt.k = s_nxt.phase[1];
      s_nxt.rd_valid = 1'b0;
      // changes land half a link phase before the edge that samples them
      rise_prep = (s_r.phase == 2'h0);
      fall_prep = (s_r.phase == 2'h2);

      // two flops on the returning data before anything looks at it
      s_nxt.q1 = link.dout;
      s_nxt.v1 = link.out_valid_flag;
      s_nxt.q2 = s_r.q1;
      s_nxt.v2 = s_r.v1;

      if (rise_prep || fall_prep) begin
         s_nxt.lane_on = '0;
         if (s_r.stage_delay == 2'h1) begin
            s_nxt.d = s_r.stage_d[0];
            s_nxt.lane_on = ~s_r.stage_m[0];
            s_nxt.shift_d = s_r.stage_d >> `DATA_W;
            s_nxt.shift_m = s_r.stage_m >> `LANES;
            s_nxt.shift_v = 4'h7;
         end else if (s_r.shift_v[0]) begin
            s_nxt.d = s_r.shift_d[0];
            s_nxt.lane_on = ~s_r.shift_m[0];
            s_nxt.shift_d = s_r.shift_d >> `DATA_W;
            s_nxt.shift_m = s_r.shift_m >> `LANES;
            s_nxt.shift_v = s_r.shift_v >> 1;
         end
         if (s_r.stage_delay != 2'h0) begin
            s_nxt.stage_delay = s_r.stage_delay - 2'h1;
         end
         // collect four valid beats, rise beat first
         if (s_r.v2) begin
            s_nxt.col[s_r.col_cnt] = s_r.q2;
            s_nxt.col_cnt = s_r.col_cnt + 2'h1;
            if (s_r.col_cnt == 2'h3) begin
               s_nxt.rd_valid = 1'b1;
               s_nxt.rd_data = s_r.col;
               s_nxt.rd_data[3] = s_r.q2;
            end
         end
      end

      if (rise_prep) begin
         s_nxt.slot = ~s_r.slot;
         s_nxt.rd_sel = rd_req && rd_ready;
         s_nxt.wr_sel = wr_req && wr_ready;
         if (rd_req && rd_ready) begin
            s_nxt.addr = rd_addr;
         end
         if (wr_req && wr_ready) begin
            s_nxt.addr = wr_addr;
            s_nxt.stage_d = wr_data;
            s_nxt.stage_m = wr_mask_n;
            s_nxt.stage_delay = 2'h2;
         end
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign link.k = s_r.k;
   assign link.k_n = ~s_r.k;
   assign link.address_pins = s_r.addr;
   assign link.rd_sel_n = ~s_r.rd_sel;
   assign link.wr_sel_n = ~s_r.wr_sel;
   assign link.din = s_r.d;
   assign link.lane_write_n = ~s_r.lane_on;
   assign link.loop_on = dll_enable;
   assign rd_valid = s_r.rd_valid;
   assign rd_data = s_r.rd_data;
endmodule

// ### verilog/sram_device_end.sv
`timescale 1ns/10ps
`include "sram_link_regs.svh"
module sram_device_end (
   sram_link_if.dev link,
   input wire logic rst
);
   link_pkg::dev_rise_type r_r;
   link_pkg::dev_rise_type r_nxt;
   link_pkg::dev_fall_type f_r;
   link_pkg::dev_fall_type f_nxt;
   logic loop_on_s;
   logic rd_now;
   logic wr_now;
   logic h0_v;
   logic h1_v;
   link_pkg::line_type h0_a;
   link_pkg::line_type h1_a;
   link_pkg::line_type pin_line;
   logic fetch_v;
   logic fetch_half;
   link_pkg::line_type fetch_a;
   link_pkg::pair_type fetch_raw;
   logic commit_v;
   logic commit_half;
   link_pkg::line_type commit_a;
   link_pkg::pair_type commit_d;
   link_pkg::pair_mask_type commit_m;

   // loop enable comes from the far side and can change while k runs, so it passes two flops on k
   sync_two loop_sync (
      .clk(link.k),
      .rst(rst),
      .din(link.loop_on),
      .dout(loop_on_s)
   );

   // storage aliases on the low address bits only
   assign pin_line = link.address_pins[`STORE_BITS-1:0];

   always_comb begin
      r_nxt = r_r;

      // command capture; a read wins if both selects are low
      rd_now = !link.rd_sel_n;
      wr_now = !link.wr_sel_n && link.rd_sel_n;
      r_nxt.rd_v1 = rd_now;
      if (rd_now) begin
         r_nxt.rd_a1 = pin_line;
      end
      r_nxt.rd_v2 = r_r.rd_v1;
      r_nxt.rd_a2 = r_r.rd_a1;
      r_nxt.wr_v1 = wr_now;
      if (wr_now) begin
         r_nxt.wr_a1 = pin_line;
      end
      r_nxt.wr_v2 = r_r.wr_v1;
      r_nxt.wr_a2 = r_r.wr_a1;
      r_nxt.wr_v3 = r_r.wr_v2;
      r_nxt.wr_a3 = r_r.wr_a2;

      // rise beat: first beat one rise after the command, then beat three
      r_nxt.beat_d = link.din;
      r_nxt.beat_m = link.lane_write_n;

      // late write: first half lands two rises on, second half three
      commit_v = r_r.wr_v2 || r_r.wr_v3;
      commit_half = r_r.wr_v3;
      commit_a = r_r.wr_v3 ? r_r.wr_a3 : r_r.wr_a2;
      commit_d[0] = r_r.beat_d;
      commit_d[1] = f_r.d;
      commit_m[0] = r_r.beat_m;
      commit_m[1] = f_r.m;
      if (commit_v) begin
         for (int j = 0; j < 2; j++) begin
            r_nxt.mem[commit_a][2 * commit_half + j] = link_pkg::merge_lanes(
               r_r.mem[commit_a][2 * commit_half + j], commit_d[j], commit_m[j]);
         end
      end

      // bypass mode pulls the fetch one rise earlier straight off the pins
      if (loop_on_s) begin
         h0_v = r_r.rd_v1;
         h0_a = r_r.rd_a1;
         h1_v = r_r.rd_v2;
         h1_a = r_r.rd_a2;
      end else begin
         h0_v = rd_now;
         h0_a = pin_line;
         h1_v = r_r.rd_v1;
         h1_a = r_r.rd_a1;
      end
      fetch_v = h0_v || h1_v;
      fetch_half = h1_v && !h0_v;
      fetch_a = h0_v ? h0_a : h1_a;
      for (int j = 0; j < 2; j++) begin
         fetch_raw[j] = r_r.mem[fetch_a][2 * fetch_half + j];
         // a half landing at this same rise is not in storage yet
         if (commit_v && commit_a == fetch_a && commit_half == fetch_half) begin
            fetch_raw[j] = link_pkg::merge_lanes(fetch_raw[j], commit_d[j], commit_m[j]);
         end
      end
      r_nxt.fetch_v = fetch_v;
      r_nxt.fetch_d = fetch_raw;
      r_nxt.launch_v = r_r.fetch_v;
      r_nxt.launch_d = r_r.fetch_d;
   end

   always_ff @(posedge link.k) begin
      if (rst) begin
         r_r <= '0;
      end else begin
         r_r <= r_nxt;
      end
   end

   always_comb begin
      f_nxt = f_r;
      f_nxt.d = link.din;
      f_nxt.m = link.lane_write_n;
      f_nxt.q = r_r.launch_d[1];
      f_nxt.valid = r_r.launch_v;
   end

   always_ff @(posedge link.k_n) begin
      if (rst) begin
         f_r <= '0;
      end else begin
         f_r <= f_nxt;
      end
   end

   // output mux on the clock level keeps each beat for half a cycle
   assign link.dout = link.k ? r_r.launch_d[0] : f_r.q;
   assign link.out_valid_flag = link.k ? r_r.launch_v : f_r.valid;
   // echoes never stop, even with the data outputs idle
   assign link.echo_strobe = link.k;
   assign link.echo_strobe_inverted = link.k_n;
endmodule

// ### verilog/sram_link_if.sv
`timescale 1ns/10ps
interface sram_link_if;
   logic k;
   logic k_n;
   link_pkg::addr_type address_pins;
   logic rd_sel_n;
   logic wr_sel_n;
   link_pkg::word_type din;
   link_pkg::mask_type lane_write_n;
   logic loop_on;
   link_pkg::word_type dout;
   logic echo_strobe;
   logic echo_strobe_inverted;
   logic out_valid_flag;

   modport ctl (
      output k,
      output k_n,
      output address_pins,
      output rd_sel_n,
      output wr_sel_n,
      output din,
      output lane_write_n,
      output loop_on,
      input dout,
      input echo_strobe,
      input echo_strobe_inverted,
      input out_valid_flag
   );

   modport dev (
      input k,
      input k_n,
      input address_pins,
      input rd_sel_n,
      input wr_sel_n,
      input din,
      input lane_write_n,
      input loop_on,
      output dout,
      output echo_strobe,
      output echo_strobe_inverted,
      output out_valid_flag
   );
endinterface

// ### verilog/sram_link_regs.svh
// What this block does
// - 2Mx36 or 4Mx18; buses follow option
// - every burst is exactly four beats
// - separate read and write data ports
// - address and selects taken at k rise
// - read and write commands use alternate rises
// - beats one, three taken at k rise
// - beats two, four taken at k_n rise
// - first write beat one cycle after command
// - lane masks travel with each beat
// - write occupies two full cycles
// - read beats one, three at rises two, three after command (loop on)
// - read beats two, four at k_n rises
// - read occupies two full cycles
// - echo strobes timed with read data
// - low select starts cycle; else address ignored
// - byte written only when lane mask low
// - valid flag high with data, echo aligned
// - loop off gives one-cycle read latency
`ifndef SRAM_LINK_REGS_SVH
`define SRAM_LINK_REGS_SVH
`define WIDE_OPTION 1
`define DATA_W ((`WIDE_OPTION) ? 36 : 18)
`define ADDR_W ((`WIDE_OPTION) ? 19 : 20)
`define LANES ((`WIDE_OPTION) ? 4 : 2)
`define LANE_W 9
`define BURST_LEN 4
`define STORE_BITS 4
`define STORE_LINES 16
`define CLK_PERIOD_NS 40
`define LINK_PERIOD_NS 160
`define CLK_PER_LINK (`LINK_PERIOD_NS / `CLK_PERIOD_NS)
`define BYPASS_MAX_MHZ 167
`endif

// ### verilog/sync_two.sv
`timescale 1ns/10ps
module sync_two (
   input wire logic clk,
   input wire logic rst,
   input wire logic din,
   output logic dout
);
   link_pkg::sync_type s_r;
   link_pkg::sync_type s_nxt;

   always_comb begin
      s_nxt = s_r;
      s_nxt.meta = din;
      s_nxt.stable = s_r.meta;
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         s_r <= '0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign dout = s_r.stable;
endmodule
